// ### bench/tomcs_source_model.sv
// source model: external trigger inputs and channel detectors
// assumes the bench sets wanted levels; outputs follow one edge later
module tomcs_source_model
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// wanted levels
	input  wire logic [9:0] want,
	// source conditions
	output logic            extWindow,
	output logic            extCmp,
	output logic      [7:0] chanCond
);
	timeunit 1ns;
	timeprecision 1ps;
	// registered so conditions never change in the sampling step
	always_ff @(posedge clock)
	begin
		{chanCond, extCmp, extWindow} <= rst_n ? want : 10'h000;
	end
endmodule

// ### bench/tomcs_trigger_or_mask_bench.sv
// self-checking bench of the trigger or-mask stage
// assumes the register map of tomcs_defines.svh
`include "tomcs_defines.svh"
module tomcs_trigger_or_mask_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 0, rst_n = 0, strap = 1, regWrite = 0, regRead = 0, acqStart = 0, acqStop = 0;
	logic [15:0] regAddr = 16'h0000;
	logic [31:0] regWriteData = 32'h0000_0000;
	logic [9:0]  want = 10'h000;
	logic [31:0] regReadData;
	logic        ew, ec, orMaskOut, triggerRequest, acqTriggered;
	logic [7:0]  ch;
	int          miscompares = 0, checked = 0;
	always #12.5 clock = ~clock;
	tomcs_source_model i_tomcs_source_model (.clock(clock), .rst_n(rst_n), .want(want), .extWindow(ew),
		.extCmp(ec), .chanCond(ch));
	tomcs_trigger_or_mask i_tomcs_trigger_or_mask (.clock(clock), .rst_n(rst_n), .adcCardStrap(strap),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .acqStart(acqStart), .acqStop(acqStop), .externalWindowInput(ew),
		.externalComparatorInput(ec), .channelTrigger(ch), .orMaskOut(orMaskOut),
		.triggerRequest(triggerRequest), .acqTriggered(acqTriggered));
	task automatic close_out;
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 chk(regReadData, exp);
	endtask
	// strap is taken at the first edge after release, so it is set first
	task automatic do_reset(input logic s);
		strap <= s;
		rst_n <= 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	function automatic logic exp_or(input logic [2:0] g, input logic [7:0] c, input logic [9:0] s);
		return g[0] | (g[1] & s[0]) | (g[2] & s[1]) | (|(c & s[9:2])) | (g == 3'h0 && c == 8'h00);
	endfunction
	task automatic or_case(input logic [2:0] g, input logic [7:0] c, input logic [9:0] s);
		wr(`TOMCS_OFS_GEN_SELECT, {29'h0, g});
		wr(`TOMCS_OFS_CHAN_SELECT, {24'h0, c});
		want <= s;
		repeat (3) @(posedge clock);
		#1 chk({31'h0, orMaskOut}, {31'h0, exp_or(g, c, s)});
	endtask
	// bounded watch for the pulse, then stop returns to idle
	task automatic acq(input logic [9:0] s, input logic hit);
		int pulses;
		pulses = 0;
		@(posedge clock);
		want <= s;
		@(posedge clock);
		acqStart <= 1'b1;
		@(posedge clock);
		acqStart <= 1'b0;
		repeat (6)
		begin
			@(posedge clock);
			#1 pulses += int'(triggerRequest === 1'b1);
		end
		// the request is a single pulse, the triggered state stands until stop
		chk(pulses, {31'h0, hit});
		chk({31'h0, acqTriggered}, {31'h0, hit});
		@(posedge clock);
		acqStop <= 1'b1;
		@(posedge clock);
		acqStop <= 1'b0;
		@(posedge clock);
		#1 chk({31'h0, acqTriggered}, 32'h0);
	endtask
	initial
	begin
		void'($urandom(55));
		do_reset(1'b1);
		rd(`TOMCS_OFS_GEN_SELECT, 32'h1);
		rd(`TOMCS_OFS_CHAN_AVAIL, 32'hFF);
		rd(`TOMCS_OFS_CHAN_SELECT, 32'h0);
		wr(`TOMCS_OFS_CHAN_AVAIL, 32'h0);
		rd(`TOMCS_OFS_CHAN_AVAIL, 32'hFF);
		rd(16'h1234, 32'h0);
		rd(`TOMCS_OFS_GEN_AVAIL, 32'h7);
		wr(16'h1234, 32'hFFFF_FFFF);
		rd(`TOMCS_OFS_GEN_SELECT, 32'h1);
		acq(10'h000, 1'b1);
		// one-hot walk with junk above the mask width
		for (int i = 0; i < 8; i++)
		begin
			wr(`TOMCS_OFS_CHAN_SELECT, 32'hFFFF_FF00 | (32'h1 << i));
			rd(`TOMCS_OFS_CHAN_SELECT, 32'h1 << i);
			or_case(3'h0, 8'h01 << i, 10'h004 << i);
			or_case(3'h0, 8'h01 << i, ~(10'h004 << i));
		end
		or_case(3'h6, 8'h00, 10'h001);
		or_case(3'h6, 8'h00, 10'h002);
		or_case(3'h6, 8'h00, 10'h000);
		rd(`TOMCS_OFS_GEN_SELECT, 32'h6);
		or_case(3'h1, 8'hFF, 10'h000);
		or_case(3'h0, 8'h00, 10'h000);
		for (int i = 0; i < 40; i++)
			or_case(3'($urandom), 8'($urandom), 10'($urandom));
		// host clears the default and selects a single source
		or_case(3'h0, 8'h01, 10'h000);
		acq(10'h3F8, 1'b0);
		acq(10'h004, 1'b1);
		@(posedge clock);
		do_reset(1'b0);
		rd(`TOMCS_OFS_CHAN_AVAIL, 32'h0);
		wr(`TOMCS_OFS_CHAN_SELECT, 32'hFF);
		rd(`TOMCS_OFS_CHAN_SELECT, 32'h0);
		close_out;
	end
endmodule

// ### design/tomcs_or_combine.sv
// one or-mask slice: enabled sources ored, with an empty-mask flag
// assumes sources are already synchronous to the clock
module tomcs_or_combine
	import tomcs_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// mask and sources
	input  wire logic [WIDTH-1:0] sourceEnable,
	input  wire logic [WIDTH-1:0] sourceActive,
	// results
	output wire logic             anyHit,
	output wire logic             maskEmpty
);
	assign anyHit    = |(sourceEnable & sourceActive);
	assign maskEmpty = ~(|sourceEnable);
endmodule

// ### design/tomcs_trigger_or_mask.sv
// trigger or-mask stage: general and channel masks, register port and start logic
// assumes a plain strobe register port and synchronous trigger condition inputs
//
// Implementation choice: strobed register access.
`include "tomcs_defines.svh"

module tomcs_trigger_or_mask
	import tomcs_pkg::*;
(
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// variant strap
	input  wire logic                       adcCardStrap,
	// register port
	input  wire logic [`TOMCS_ADDR_W-1:0]   regAddr,
	input  wire logic [`TOMCS_DATA_W-1:0]   regWriteData,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	output logic      [`TOMCS_DATA_W-1:0]   regReadData,
	// acquisition control
	input  wire logic                       acqStart,
	input  wire logic                       acqStop,
	// trigger sources
	input  wire logic                       externalWindowInput,
	input  wire logic                       externalComparatorInput,
	input  wire logic [`TOMCS_CHAN_W-1:0]   channelTrigger,
	// results
	output logic                            orMaskOut,
	output logic                            triggerRequest,
	output logic                            acqTriggered
);
	logic [`TOMCS_GEN_W-1:0]   generalOrSelect;
	logic [`TOMCS_CHAN_W-1:0]  channelOrSelect;
	logic                      adcVariant;
	logic                      strapTaken;
	tomcs_acq_e                acqState;
	tomcs_acq_e                next_acqState;

	function automatic logic regHit(input logic [`TOMCS_ADDR_W-1:0] addr,
	                                input logic [`TOMCS_ADDR_W-1:0] ofs);
		regHit = (addr == ofs);
	endfunction

	wire logic                       hitGenAvail  = regHit(regAddr, `TOMCS_OFS_GEN_AVAIL);
	wire logic                       hitGenSel    = regHit(regAddr, `TOMCS_OFS_GEN_SELECT);
	wire logic                       hitChanAvail = regHit(regAddr, `TOMCS_OFS_CHAN_AVAIL);
	wire logic                       hitChanSel   = regHit(regAddr, `TOMCS_OFS_CHAN_SELECT);

	// channel sources only on adc variants
	wire logic [`TOMCS_CHAN_W-1:0]   channelAvail = adcVariant ? `TOMCS_CHAN_ALL : `TOMCS_NO_SOURCE_CHAN;

	wire logic [`TOMCS_GEN_W-1:0]    generalActive;
	assign generalActive[`TOMCS_BIT_SW]         = 1'b1;
	assign generalActive[`TOMCS_BIT_EXT_WINDOW] = externalWindowInput;
	assign generalActive[`TOMCS_BIT_EXT_CMP]    = externalComparatorInput;

	wire logic                       generalHit;
	wire logic                       generalEmpty;
	wire logic                       channelHit;
	wire logic                       channelEmpty;

	// software source is always active, so its bit alone forces a hit
	// either external condition counts when its bit is set
	tomcs_or_combine #(.WIDTH(`TOMCS_GEN_W)) generalSlice (
		.sourceEnable (generalOrSelect),
		.sourceActive (generalActive),
		.anyHit       (generalHit),
		.maskEmpty    (generalEmpty)
	);

	// channel n enabled by bit n
	tomcs_or_combine #(.WIDTH(`TOMCS_CHAN_W)) channelSlice (
		.sourceEnable (channelOrSelect),
		.sourceActive (channelTrigger),
		.anyHit       (channelHit),
		.maskEmpty    (channelEmpty)
	);

	// empty masks pass true so the and stage is not blocked
	wire logic orHit = generalHit | channelHit | (generalEmpty & channelEmpty);

	wire logic [`TOMCS_DATA_W-1:0] readMux =
		hitGenAvail  ? {{(`TOMCS_DATA_W-`TOMCS_GEN_W){1'b0}}, `TOMCS_GEN_AVAIL_VAL} :
		hitGenSel    ? {{(`TOMCS_DATA_W-`TOMCS_GEN_W){1'b0}}, generalOrSelect} :
		hitChanAvail ? {{(`TOMCS_DATA_W-`TOMCS_CHAN_W){1'b0}}, channelAvail} :
		hitChanSel   ? {{(`TOMCS_DATA_W-`TOMCS_CHAN_W){1'b0}}, channelOrSelect} :
		`TOMCS_READ_ZERO;

	// strap caught once after reset release, so a late-settling pin is not missed
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			adcVariant <= 1'b0;
			strapTaken <= 1'b0;
		end
		else if (!strapTaken)
		begin
			adcVariant <= adcCardStrap;
			strapTaken <= 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			generalOrSelect <= `TOMCS_GEN_RESET;
		else if (regWrite && hitGenSel)
			generalOrSelect <= regWriteData[`TOMCS_GEN_W-1:0];
	end

	// channel mask write, limited to sources that exist
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			channelOrSelect <= `TOMCS_NO_SOURCE_CHAN;
		else if (regWrite && hitChanSel)
			channelOrSelect <= regWriteData[`TOMCS_CHAN_W-1:0] & channelAvail;
		else
			channelOrSelect <= channelOrSelect & channelAvail;
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			regReadData <= `TOMCS_READ_ZERO;
		else if (regRead)
			regReadData <= readMux;
		else
			regReadData <= `TOMCS_READ_ZERO;
	end

	always_comb
	begin
		next_acqState = acqState;
		case (acqState)
			ACQ_IDLE:
				if (acqStart)
					next_acqState = ACQ_WAIT;
			ACQ_WAIT:
				if (acqStop)
					next_acqState = ACQ_IDLE;
				else if (orHit)
					next_acqState = ACQ_DONE;
			ACQ_DONE:
				if (acqStop)
					next_acqState = ACQ_IDLE;
			default:
				next_acqState = ACQ_IDLE;
		endcase
	end

	// first hit after start becomes a one-cycle request
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			acqState       <= ACQ_IDLE;
			triggerRequest <= 1'b0;
			orMaskOut      <= 1'b0;
		end
		else
		begin
			acqState       <= next_acqState;
			triggerRequest <= (acqState == ACQ_WAIT) && !acqStop && orHit;
			orMaskOut      <= orHit;
		end
	end

	assign acqTriggered = (acqState == ACQ_DONE);

	a_reset_default: assert property (@(posedge clock)
		$rose(rst_n) |-> generalOrSelect == `TOMCS_GEN_RESET)
		else $error("general mask not at software default after reset");

	a_sw_override: assert property (@(posedge clock) disable iff (!rst_n)
		generalOrSelect[`TOMCS_BIT_SW] |=> orMaskOut)
		else $error("software source did not force the or output");

	a_ext_either: assert property (@(posedge clock) disable iff (!rst_n)
		(generalOrSelect[`TOMCS_BIT_EXT_WINDOW] && externalWindowInput) ||
		(generalOrSelect[`TOMCS_BIT_EXT_CMP] && externalComparatorInput) |=> orMaskOut)
		else $error("external condition did not raise the or output");

	a_avail_read: assert property (@(posedge clock) disable iff (!rst_n)
		regRead && hitChanAvail |=> regReadData == {{(`TOMCS_DATA_W-`TOMCS_CHAN_W){1'b0}}, channelAvail})
		else $error("channel availability read back wrong");

	a_chan_write: assert property (@(posedge clock) disable iff (!rst_n)
		regWrite && hitChanSel |=> channelOrSelect == ($past(regWriteData[`TOMCS_CHAN_W-1:0]) & channelAvail))
		else $error("channel mask write not stored");

	a_chan_onehot: assert property (@(posedge clock) disable iff (!rst_n)
		|(channelOrSelect & channelTrigger) |=> orMaskOut)
		else $error("enabled channel trigger not seen");

	a_variant_none: assert property (@(posedge clock) disable iff (!rst_n)
		strapTaken && !adcVariant |=> channelOrSelect == `TOMCS_NO_SOURCE_CHAN)
		else $error("channel mask set on a non-adc variant");

	a_start_fires: assert property (@(posedge clock) disable iff (!rst_n)
		acqState == ACQ_IDLE && acqStart && generalOrSelect[`TOMCS_BIT_SW] && !acqStop ##1
		!acqStop && generalOrSelect[`TOMCS_BIT_SW] |=> triggerRequest && acqTriggered)
		else $error("software trigger did not fire after start");

	a_empty_true: assert property (@(posedge clock) disable iff (!rst_n)
		generalOrSelect == `TOMCS_NO_SOURCE_GEN && channelOrSelect == `TOMCS_NO_SOURCE_CHAN |=> orMaskOut)
		else $error("empty masks did not pass true");

	a_combined_or: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && !orMaskOut |-> !$past(generalHit) && !$past(channelHit))
		else $error("or output low although a source hit");
endmodule

// ### pkg/tomcs_defines.svh
// register map, field positions and reset values of the trigger or-mask stage
// assumes a 16-bit register address and 32-bit register data
`ifndef TOMCS_DEFINES_SVH
`define TOMCS_DEFINES_SVH

`define TOMCS_ADDR_W            16
`define TOMCS_DATA_W            32
`define TOMCS_GEN_W             3
`define TOMCS_CHAN_W            8

`define TOMCS_OFS_GEN_AVAIL     16'h9DD0
`define TOMCS_OFS_GEN_SELECT    16'h9DDA
`define TOMCS_OFS_CHAN_AVAIL    16'h9E02
`define TOMCS_OFS_CHAN_SELECT   16'h9E0C

`define TOMCS_BIT_SW            0
`define TOMCS_BIT_EXT_WINDOW    1
`define TOMCS_BIT_EXT_CMP       2

`define TOMCS_GEN_AVAIL_VAL     3'h7
`define TOMCS_GEN_RESET         3'h1
`define TOMCS_NO_SOURCE_GEN     3'h0
`define TOMCS_NO_SOURCE_CHAN    8'h00
`define TOMCS_CHAN_ALL          8'hFF
`define TOMCS_READ_ZERO         32'h0000_0000

`endif

// ### pkg/tomcs_pkg.sv
// types shared by the trigger or-mask stage
// assumes tomcs_defines.svh is on the include path
package tomcs_pkg;
	typedef enum logic [1:0] {
		ACQ_IDLE,
		ACQ_WAIT,
		ACQ_DONE
	} tomcs_acq_e;
endpackage
